// ==== pkg/uic_defs.svh ====
// Constants of the USB microcontroller interrupt controller
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH

`define UIC_OFS_GLOBAL_EN   8'h20
`define UIC_OFS_EP_EN       8'h21
`define UIC_OFS_STATUS      8'hff
`define UIC_OFS_ADDR_A      8'h10
`define UIC_OFS_ADDR_B      8'h40

`define UIC_GLOBAL_EN_MASK  8'h77
`define UIC_EP_EN_MASK      8'h1f
`define UIC_STAT_PEND_BIT   7
`define UIC_STAT_BRST_BIT   5
`define UIC_STAT_GIE_BIT    2
`define UIC_GE_TWI_BIT      6

`define UIC_NUM_SRC         12
`define UIC_RESET_VEC       14'h0000
`define UIC_VEC_STEP        14'h0002

`define UIC_CLK_PERIOD_NS   50
`define UIC_SE0_MIN_NS      12000
`define UIC_SE0_CYC         ((`UIC_SE0_MIN_NS + `UIC_CLK_PERIOD_NS - 1) / `UIC_CLK_PERIOD_NS)
`define UIC_CALL_CYC        10
`define UIC_JUMP_CYC        5

`endif

// ==== pkg/uic_pkg.sv ====
// Types of the USB microcontroller interrupt controller
`default_nettype none
package uic_pkg;
    typedef enum logic [1:0] {
        UIC_IDLE = 2'b00,
        UIC_CALL = 2'b01,
        UIC_JUMP = 2'b10
    } uic_state_t;
    typedef logic [3:0] uic_src_t;
endpackage
`default_nettype wire

// ==== rtl/uic_top.sv ====
// Interrupt controller with bus reset detection and service sequencer
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uic_defs.svh"
module uic_top #(
    parameter int SE0_CYC  = `UIC_SE0_CYC,
    parameter int CALL_CYC = `UIC_CALL_CYC,
    parameter int JUMP_CYC = `UIC_JUMP_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic        i_dp,
    input  wire logic        i_dm,
    input  wire logic        i_tmr128_evt,
    input  wire logic        i_tmr1024_evt,
    input  wire logic [4:0]  i_ep_in_ack,
    input  wire logic [4:0]  i_ep_out_ack,
    input  wire logic        i_dac_evt,
    input  wire logic        i_gpio_evt,
    input  wire logic        i_twi_evt,
    input  wire logic        i_instr_done,
    input  wire logic        i_irq_disable_instr,
    input  wire logic        i_irq_enable_instr,
    input  wire logic        i_return_from_service_instr,
    input  wire logic [13:0] i_pc,
    input  wire logic        i_carry_flag,
    input  wire logic        i_zero_flag,
    input  wire logic [15:0] i_stack_rdata,
    output logic             o_stack_wr,
    output logic      [15:0] o_stack_wdata,
    output logic             o_pc_load,
    output logic      [13:0] o_pc_value,
    output logic             o_flag_load,
    output logic             o_carry_flag,
    output logic             o_zero_flag,
    output logic             o_service_busy,
    output logic             o_service_entry,
    output logic             o_gie,
    output logic             o_bus_reset,
    output logic             o_abort_startup,
    output logic      [7:0]  o_usb_addr_a,
    output logic      [7:0]  o_usb_addr_b
);
    import uic_pkg::*;
    localparam int N = `UIC_NUM_SRC;
    logic [7:0]   ge_q, ep_q;
    logic [N-1:0] pend_q, evt, en, req, clr;
    logic [2:0]   dp_s_q, dm_s_q;
    logic [8:0]   se0_cnt_q;
    logic [3:0]   cnt_q;
    logic [13:0]  vec_q;
    uic_src_t     sel, sel_q;
    uic_state_t   state_q;
    logic         brst_flag_q, brst_act_q, dp_q, dm_q;
    logic         se0, brst_det, brst_end;
    logic         any_req, take, call_done;

    // Register writes
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ge_q <= 8'h00;
            ep_q <= 8'h00;
        end
        else if (i_wr)
        begin
            if (i_addr == `UIC_OFS_GLOBAL_EN)
                ge_q <= i_wdata & `UIC_GLOBAL_EN_MASK;
            if (i_addr == `UIC_OFS_EP_EN)
                ep_q <= i_wdata & `UIC_EP_EN_MASK;
        end
    end

    // Device address registers, wiped by a bus reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_usb_addr_a <= 8'h00;
            o_usb_addr_b <= 8'h00;
        end
        else if (brst_det)
        begin
            o_usb_addr_a <= 8'h00;
            o_usb_addr_b <= 8'h00;
        end
        else if (i_wr)
        begin
            if (i_addr == `UIC_OFS_ADDR_A)
                o_usb_addr_a <= i_wdata;
            if (i_addr == `UIC_OFS_ADDR_B)
                o_usb_addr_b <= i_wdata;
        end
    end

    // Status bit 5: detection wins over a software write
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            brst_flag_q <= 1'b0;
        else if (brst_det)
            brst_flag_q <= 1'b1;
        else if (i_wr && i_addr == `UIC_OFS_STATUS)
            brst_flag_q <= i_wdata[`UIC_STAT_BRST_BIT];
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `UIC_OFS_GLOBAL_EN: o_rdata <= ge_q;
                `UIC_OFS_EP_EN:     o_rdata <= ep_q;
                `UIC_OFS_ADDR_A:    o_rdata <= o_usb_addr_a;
                `UIC_OFS_ADDR_B:    o_rdata <= o_usb_addr_b;
                `UIC_OFS_STATUS:
                begin
                    o_rdata <= 8'h00;
                    o_rdata[`UIC_STAT_PEND_BIT] <= |pend_q;
                    o_rdata[`UIC_STAT_BRST_BIT] <= brst_flag_q;
                    o_rdata[`UIC_STAT_GIE_BIT]  <= o_gie;
                end
                default:            o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

    // Upstream line synchronisers
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            dp_s_q <= 3'h7;
            dm_s_q <= 3'h0;
            dp_q   <= 1'b1;
            dm_q   <= 1'b0;
        end
        else
        begin
            dp_s_q <= {dp_s_q[1:0], i_dp};
            dm_s_q <= {dm_s_q[1:0], i_dm};
            if (dp_s_q[1] == dp_s_q[2])
                dp_q <= dp_s_q[2];
            if (dm_s_q[1] == dm_s_q[2])
                dm_q <= dm_s_q[2];
        end
    end

    assign se0 = ~dp_q & ~dm_q;
    // SE0 duration count; recognised at the 12 us minimum
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || !se0)
            se0_cnt_q <= 9'h000;
        else if (se0_cnt_q != 9'(SE0_CYC))
            se0_cnt_q <= se0_cnt_q + 9'h001;
    end
    assign brst_det = se0 && (se0_cnt_q == 9'(SE0_CYC - 1));
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            brst_act_q <= 1'b0;
        else if (brst_det)
            brst_act_q <= 1'b1;
        else if (!se0)
            brst_act_q <= 1'b0;
    end
    assign brst_end = brst_act_q && !se0;
    // Bus reset pulses, held low in reset
    always_ff @(posedge i_core_clk)
    begin
        o_bus_reset     <= !i_rst && brst_det;
        o_abort_startup <= !i_rst && brst_det;
    end

    // Source events and enables in vector order
    always_comb
    begin
        evt      = '0;
        evt[0]   = brst_end;
        evt[1]   = i_tmr128_evt;
        evt[2]   = i_tmr1024_evt;
        evt[7:3] = i_ep_in_ack | i_ep_out_ack;
        evt[9]   = i_dac_evt;
        evt[10]  = i_gpio_evt;
        evt[11]  = i_twi_evt;
        en       = '0;
        en[2:0]  = ge_q[2:0];
        en[7:3]  = ep_q[4:0];
        en[9]    = ge_q[4];
        en[10]   = ge_q[5];
        en[11]   = ge_q[`UIC_GE_TWI_BIT];
    end

    // Pending flops; a new event wins over the service clear
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_pend
            assign clr[g] = take && (sel == uic_src_t'(g));
            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                    pend_q[g] <= 1'b0;
                else
                    pend_q[g] <= (pend_q[g] & ~clr[g]) | evt[g];
            end
        end
    endgenerate
    assign req     = pend_q & en;
    assign any_req = |req;
    // Lowest-numbered request wins
    always_comb
    begin
        sel = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
                sel = uic_src_t'(i);
        end
    end
    assign take = (state_q == UIC_IDLE) && i_instr_done && o_gie && any_req;
    // Global enable: service clears, return and enable set, disable clears
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            o_gie <= 1'b0;
        else if (take)
            o_gie <= 1'b0;
        else if (i_return_from_service_instr || i_irq_enable_instr)
            o_gie <= 1'b1;
        else if (i_irq_disable_instr)
            o_gie <= 1'b0;
    end

    // Service sequencer; the take cycle counts toward the call, the load comes in the cycle after it
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_q <= UIC_IDLE;
            cnt_q   <= 4'h0;
            sel_q   <= '0;
            vec_q   <= `UIC_RESET_VEC;
        end
        else
        begin
            case (state_q)
                UIC_IDLE:
                begin
                    if (take)
                    begin
                        state_q <= UIC_CALL;
                        cnt_q   <= 4'(CALL_CYC - 2);
                        sel_q   <= sel;
                        vec_q   <= {9'h000, sel, 1'b0} + `UIC_VEC_STEP;
                    end
                end
                UIC_CALL:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q <= UIC_JUMP;
                        cnt_q   <= 4'(JUMP_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                UIC_JUMP:
                begin
                    if (cnt_q == 4'h0)
                        state_q <= UIC_IDLE;
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                default:
                    state_q <= UIC_IDLE;
            endcase
        end
    end

    assign call_done = (state_q == UIC_CALL) && (cnt_q == 4'h0);
    // Stack push of counter and flags on the automatic call
    always_ff @(posedge i_core_clk)
    begin
        o_stack_wr <= !i_rst && take;
        if (i_rst)
            o_stack_wdata <= 16'h0000;
        else if (take)
            o_stack_wdata <= {i_zero_flag, i_carry_flag, i_pc};
    end

    // Program counter load: reset vector, service vector or return
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_pc_load    <= 1'b1;
            o_pc_value   <= `UIC_RESET_VEC;
            o_flag_load  <= 1'b0;
            o_carry_flag <= 1'b0;
            o_zero_flag  <= 1'b0;
        end
        else if (call_done)
        begin
            o_pc_load   <= 1'b1;
            o_pc_value  <= vec_q;
            o_flag_load <= 1'b0;
        end
        else if (i_return_from_service_instr)
        begin
            o_pc_load    <= 1'b1;
            o_pc_value   <= i_stack_rdata[13:0];
            o_flag_load  <= 1'b1;
            o_carry_flag <= i_stack_rdata[14];
            o_zero_flag  <= i_stack_rdata[15];
        end
        else
        begin
            o_pc_load   <= 1'b0;
            o_flag_load <= 1'b0;
        end
    end
    // Sequencer busy level and entry pulse
    always_ff @(posedge i_core_clk)
    begin
        o_service_busy  <= !i_rst && (take || (state_q != UIC_IDLE
                           && !(state_q == UIC_JUMP && cnt_q == 4'h0)));
        o_service_entry <= !i_rst && (state_q == UIC_JUMP) && (cnt_q == 4'h0);
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    a_twi_gated: assert property (
        take && sel == 4'hb |-> ge_q[`UIC_GE_TWI_BIT])
        else $error("two-wire interrupt taken while disabled");
    a_reset_clears_en: assert property (
        $past(i_rst) |-> ge_q == 8'h00 && ep_q == 8'h00 && !o_gie)
        else $error("enables not cleared by reset");
    a_take_gated: assert property (
        take |-> en[sel] && pend_q[sel])
        else $error("service of a disabled or idle source");
    a_take_clears: assert property (
        take |=> !o_gie && o_stack_wr && !pend_q[sel_q] || pend_q[sel_q] && $past(evt[sel]))
        else $error("service did not clear enable and pending");
    a_call_latency: assert property (
        take |-> ##10 o_pc_load && o_pc_value == vec_q ##5 o_service_entry)
        else $error("call or jump latency wrong");
    a_stack_push: assert property (
        take |=> o_stack_wdata == {$past(i_zero_flag), $past(i_carry_flag), $past(i_pc)})
        else $error("pushed state mismatch");
    a_return_restore: assert property (
        i_return_from_service_instr && !call_done && !take
        |=> o_gie && o_pc_load && o_flag_load && o_pc_value == $past(i_stack_rdata[13:0]))
        else $error("return did not restore state");
    a_ei_only_gie: assert property (
        i_irq_enable_instr && !i_wr && !take |=> o_gie && $stable(ge_q) && $stable(ep_q))
        else $error("enable instruction disturbed enable registers");
    a_pend_sense: assert property (
        i_rd && i_addr == `UIC_OFS_STATUS && |pend_q |=> o_rdata[`UIC_STAT_PEND_BIT])
        else $error("pending not visible in status");
    a_fixed_priority: assert property (
        take |-> (req & ~({N{1'b1}} << sel)) == '0)
        else $error("lower-numbered request skipped");
    a_brst_record: assert property (
        brst_det |=> brst_flag_q && o_usb_addr_a == 8'h00 && o_usb_addr_b == 8'h00
        && o_abort_startup)
        else $error("bus reset not recorded");
    a_brst_at_end: assert property (
        brst_act_q && !se0 |=> pend_q[0] || $past(take && sel == 4'h0))
        else $error("bus reset interrupt not raised at SE0 end");
    a_ep_event: assert property (
        i_ep_in_ack[0] |=> pend_q[3] || $past(take && sel == 4'h3))
        else $error("endpoint handshake lost");
endmodule
`default_nettype wire

// ==== verif/uic_core_model.sv ====
// Behavioural model of the processor core seen by the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module uic_core_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_run,
    input  wire logic        i_busy,
    input  wire logic        i_push,
    input  wire logic [15:0] i_push_data,
    input  wire logic        i_pop,
    input  wire logic        i_pc_load,
    input  wire logic [13:0] i_pc_value,
    input  wire logic        i_flag_load,
    input  wire logic        i_carry,
    input  wire logic        i_zero,
    output logic             o_instr_done,
    output logic      [13:0] o_pc,
    output logic             o_carry_flag,
    output logic             o_zero_flag,
    output logic      [15:0] o_stack_rdata,
    output logic      [15:0] o_last_word
);
    logic [15:0] mem [0:15];
    logic [3:0]  sp;
    logic [1:0]  phase;
    initial
    begin
        sp = 4'h0;
        phase = 2'h0;
        o_pc = 14'h0000;
        o_carry_flag = 1'b0;
        o_zero_flag = 1'b0;
        o_last_word = 16'h0000;
    end
    // Instructions end every fourth cycle, none while the call sequence runs
    assign o_instr_done = i_run && !i_busy && phase == 2'h3;
    assign o_stack_rdata = mem[sp - 4'h1];
    always @(posedge i_core_clk)
    begin
        phase <= phase + 2'h1;
        if (o_instr_done)
        begin
            o_last_word <= {o_zero_flag, o_carry_flag, o_pc};
            o_pc <= o_pc + 14'h0001;
            o_carry_flag <= ~o_carry_flag;
            o_zero_flag <= o_pc[0];
        end
        if (i_pc_load)
            o_pc <= i_pc_value;
        if (i_flag_load)
        begin
            o_carry_flag <= i_carry;
            o_zero_flag <= i_zero;
        end
        if (i_push)
        begin
            mem[sp] <= i_push_data;
            sp <= sp + 4'h1;
        end
        else if (i_pop)
            sp <= sp - 4'h1;
    end
endmodule
`default_nettype wire

// ==== verif/usb_mcu_interrupt_controller_test.sv ====
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module usb_mcu_interrupt_controller_test;
    logic i_core_clk, i_rst, i_wr, i_rd, i_dp, i_dm, i_tmr128_evt, i_tmr1024_evt;
    logic i_dac_evt, i_gpio_evt, i_twi_evt, i_instr_done, i_irq_disable_instr;
    logic i_irq_enable_instr, i_return_from_service_instr, i_carry_flag, i_zero_flag;
    logic [7:0] i_addr, i_wdata, o_rdata, o_usb_addr_a, o_usb_addr_b, v;
    logic [4:0] i_ep_in_ack, i_ep_out_ack;
    logic [13:0] i_pc, o_pc_value;
    logic [15:0] i_stack_rdata, o_stack_wdata, last_word, saved;
    logic o_stack_wr, o_pc_load, o_flag_load, o_carry_flag, o_zero_flag, o_service_busy;
    logic o_service_entry, o_gie, o_bus_reset, o_abort_startup, run;
    int num_errors, checks, pushes, brsts, p0;
    logic [23:0] rows [6] = '{24'h20ff77, 24'h21ff1f, 24'h305500, 24'h103c3c,
                              24'h40c3c3, 24'hff2420};
    int srcs [10] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11};

    uic_top #(.SE0_CYC(8), .CALL_CYC(10), .JUMP_CYC(5)) u_uic_top (
        .i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_dp, .i_dm,
        .i_tmr128_evt, .i_tmr1024_evt, .i_ep_in_ack, .i_ep_out_ack, .i_dac_evt,
        .i_gpio_evt, .i_twi_evt, .i_instr_done, .i_irq_disable_instr,
        .i_irq_enable_instr, .i_return_from_service_instr, .i_pc, .i_carry_flag,
        .i_zero_flag, .i_stack_rdata, .o_stack_wr, .o_stack_wdata, .o_pc_load,
        .o_pc_value, .o_flag_load, .o_carry_flag, .o_zero_flag, .o_service_busy,
        .o_service_entry, .o_gie, .o_bus_reset, .o_abort_startup, .o_usb_addr_a,
        .o_usb_addr_b);
    uic_core_model u_uic_core_model (.i_core_clk, .i_run(run), .i_busy(o_service_busy),
        .i_push(o_stack_wr), .i_push_data(o_stack_wdata),
        .i_pop(i_return_from_service_instr), .i_pc_load(o_pc_load),
        .i_pc_value(o_pc_value), .i_flag_load(o_flag_load), .i_carry(o_carry_flag),
        .i_zero(o_zero_flag), .o_instr_done(i_instr_done), .o_pc(i_pc),
        .o_carry_flag(i_carry_flag), .o_zero_flag(i_zero_flag),
        .o_stack_rdata(i_stack_rdata), .o_last_word(last_word));

    initial
    begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    always @(negedge i_core_clk)
    begin
        if (o_stack_wr === 1'b1)
            pushes++;
        if (o_bus_reset === 1'b1)
            brsts++;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic instr(input int k);
        @(posedge i_core_clk);
        i_irq_disable_instr <= (k == 0);
        i_irq_enable_instr <= (k == 1);
        @(posedge i_core_clk);
        i_irq_disable_instr <= 1'b0;
        i_irq_enable_instr <= 1'b0;
    endtask
    task automatic src(input int s);
        @(posedge i_core_clk);
        case (s)
            1: i_tmr128_evt <= 1'b1;
            2: i_tmr1024_evt <= 1'b1;
            9: i_dac_evt <= 1'b1;
            10: i_gpio_evt <= 1'b1;
            11: i_twi_evt <= 1'b1;
            default:
                if (s % 2 == 1)
                    i_ep_in_ack[s-3] <= 1'b1;
                else
                    i_ep_out_ack[s-3] <= 1'b1;
        endcase
        @(posedge i_core_clk);
        {i_tmr128_evt, i_tmr1024_evt, i_dac_evt, i_gpio_evt, i_twi_evt} <= 5'h00;
        i_ep_in_ack <= 5'h00;
        i_ep_out_ack <= 5'h00;
    endtask
    task automatic service(input logic [13:0] vec);
        int n;
        n = 0;
        while (o_stack_wr !== 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        chk(o_stack_wr, 1, "push");
        chk(o_gie, 0, "gie at take");
        saved = last_word;
        chk(o_stack_wdata, saved, "stack word");
        for (n = 0; n < 20 && o_pc_load !== 1'b1; n++)
            cyc(1);
        chk(16'(n), 16'd9, "call cycles");
        chk(o_pc_value, vec, "vector");
        for (n = 0; n < 20 && o_service_entry !== 1'b1; n++)
            cyc(1);
        chk(16'(n), 16'd5, "jump cycles");
    endtask
    task automatic ret;
        @(posedge i_core_clk);
        i_return_from_service_instr <= 1'b1;
        @(posedge i_core_clk);
        i_return_from_service_instr <= 1'b0;
        #1;
        chk({o_pc_load, o_flag_load, o_gie}, 3'b111, "return loads");
        chk(o_pc_value, saved[13:0], "return pc");
        chk({o_zero_flag, o_carry_flag}, saved[15:14], "return flags");
    endtask
    task automatic end_of_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #(20000 * 50);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial
    begin
        {i_rst, i_wr, i_rd, i_dp, i_dm, run} = 6'b100100;
        {i_tmr128_evt, i_tmr1024_evt, i_dac_evt, i_gpio_evt, i_twi_evt} = 5'h00;
        {i_irq_disable_instr, i_irq_enable_instr, i_return_from_service_instr} = 3'h0;
        {i_addr, i_wdata, i_ep_in_ack, i_ep_out_ack} = 26'h0;
        cyc(12);
        chk({o_pc_load, o_pc_value}, 15'h4000, "reset vector");
        i_rst <= 1'b0;
        rd_reg(8'h20);
        chk(v, 8'h00, "global enable reset");
        rd_reg(8'h21);
        chk(v, 8'h00, "endpoint enable reset");
        $display("test reset done");
        foreach (rows[i])
        begin
            wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_reg(rows[i][23:16]);
            chk(v, rows[i][7:0], "register row");
        end
        wr_reg(8'hff, 8'h00);
        $display("test registers done");
        run <= 1'b1;
        instr(1);
        foreach (srcs[i])
        begin
            src(srcs[i]);
            service(14'(2 * (srcs[i] + 1)));
            ret();
        end
        $display("test vectors done");
        wr_reg(8'h20, 8'h37);
        p0 = pushes;
        src(11);
        cyc(40);
        chk(16'(pushes), 16'(p0), "masked source serviced");
        rd_reg(8'hff);
        chk(v, 8'h84, "pending while masked");
        wr_reg(8'h20, 8'h77);
        service(14'h0018);
        ret();
        $display("test masking done");
        run <= 1'b0;
        cyc(6);
        p0 = pushes;
        src(1);
        cyc(30);
        chk(16'(pushes), 16'(p0), "service without boundary");
        run <= 1'b1;
        service(14'h0004);
        ret();
        $display("test boundary done");
        instr(0);
        src(11);
        src(2);
        rd_reg(8'hff);
        chk(v, 8'h80, "pending sense");
        rd_reg(8'h20);
        chk(v, 8'h77, "enable after disable");
        instr(1);
        service(14'h0006);
        ret();
        service(14'h0018);
        ret();
        $display("test priority done");
        p0 = brsts;
        i_dp <= 1'b0;
        cyc(3);
        i_dp <= 1'b1;
        cyc(10);
        chk(16'(brsts), 16'(p0), "short SE0 recognised");
        i_dp <= 1'b0;
        for (int n = 0; n < 30 && o_bus_reset !== 1'b1; n++)
            cyc(1);
        chk({o_bus_reset, o_abort_startup}, 2'b11, "bus reset");
        p0 = pushes;
        cyc(20);
        chk({o_usb_addr_a, o_usb_addr_b}, 16'h0000, "address clear");
        chk(16'(pushes), 16'(p0), "service during SE0");
        rd_reg(8'hff);
        chk(v, 8'h24, "bus reset flag");
        i_dp <= 1'b1;
        service(14'h0002);
        ret();
        $display("test bus reset done");
        i_rst <= 1'b1;
        cyc(2);
        i_rst <= 1'b0;
        rd_reg(8'h20);
        chk(v, 8'h00, "enable after second reset");
        chk(o_gie, 1'b0, "gie after second reset");
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
